// ==== design/lintmc_top.sv ====
/*
 * lintmc_top: operating-mode controller of a single-wire LIN transceiver.
 * holds the mode machine, transmit path, receive path and fault flag pin.
 * assumes all pins arrive asynchronously and are synchronised here; the
 * analog driver and thermal sensor are outside and seen as logic levels.
 */
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module lintmc_top (
    input  wire logic ref_clk,              // 100 MHz clock
    input  wire logic sys_rst,              // async reset, active high
    input  wire logic mode_select,          // chip select from host
    input  wire logic tx_data,              // transmit data from host uart
    input  wire logic wake_n,               // wake input, falling edge wakes
    input  wire logic tx_inhibit_flag_pin_i,// inhibit pin level seen on wire
    input  wire logic bus_line_i,           // bus level vs bus_low_threshold
    input  wire logic thermal_overtemp,     // die above shutdown threshold
    input  wire logic output_overload,      // bus driver overcurrent
    input  wire logic thermal_recovered,    // die below recovery threshold
    output logic      bus_line_o,           // bus driver data, 0 dominant
    output logic      bus_line_oe,          // bus driver enable
    output logic      rx_data_o,            // receive pin data
    output logic      rx_data_oe,           // receive pin pulls low when high
    output logic      tx_inhibit_flag_pin_o,// inhibit pin data, always 0
    output logic      tx_inhibit_flag_pin_oe,// inhibit pin pulls low on thermal or dominant-short fault
    output logic      reg_enable,           // external regulator enable
    output logic      rx_enable,            // receiver powered
    output logic      tx_enable,            // transmitter enabled
    output logic [2:0] mode_o               // current mode code
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic sel_s;       // synchronised mode select
    logic txd_s;       // synchronised transmit data
    logic wake_s;      // synchronised wake
    logic inh_s;       // synchronised inhibit pin
    logic bus_s;       // synchronised bus level
    logic otemp_s;     // synchronised overtemperature
    logic ovld_s;      // synchronised overload
    logic recov_s;     // synchronised recovery

    // inputs synchronised first
    // select idles low, as with its pull-down
    lintmc_sync u_sync_sel (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .rst_val  (1'b0),
        .async_in (mode_select),
        .sync_out (sel_s)
    );

    // transmit idles high, recessive
    lintmc_sync u_sync_txd (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .rst_val  (1'b1),
        .async_in (tx_data),
        .sync_out (txd_s)
    );

    // wake idles high, so no falling edge right after reset
    lintmc_sync u_sync_wak (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .rst_val  (1'b1),
        .async_in (wake_n),
        .sync_out (wake_s)
    );

    // inhibit pin idles high, transmitter allowed
    lintmc_sync u_sync_inh (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .rst_val  (1'b1),
        .async_in (tx_inhibit_flag_pin_i),
        .sync_out (inh_s)
    );

    // bus idles recessive high, so the debounce does not start in reset
    lintmc_sync u_sync_bus (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .rst_val  (1'b1),
        .async_in (bus_line_i),
        .sync_out (bus_s)
    );

    // overtemperature idles low
    lintmc_sync u_sync_otp (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .rst_val  (1'b0),
        .async_in (thermal_overtemp),
        .sync_out (otemp_s)
    );

    // overload idles low
    lintmc_sync u_sync_ovl (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .rst_val  (1'b0),
        .async_in (output_overload),
        .sync_out (ovld_s)
    );

    // recovery idles low, a latched shutdown stays until it is seen
    lintmc_sync u_sync_rec (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .rst_val  (1'b0),
        .async_in (thermal_recovered),
        .sync_out (recov_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // edge history, taken from synchronised levels only

    logic sel_prev_q;    // mode select one cycle ago
    logic wake_prev_q;   // wake one cycle ago
    logic txd_prev_q;    // transmit data one cycle ago
    logic armed_q;       // high from the first edge after reset release
    logic started_q;     // high once the select synchroniser holds a real sample

    // history flops start at idle levels so no edge is seen at reset
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_prev_q  <= 1'b0;
            wake_prev_q <= 1'b1;
            txd_prev_q  <= 1'b1;
            armed_q     <= 1'b0;
            started_q   <= 1'b0;
        end else begin
            sel_prev_q  <= sel_s;
            wake_prev_q <= wake_s;
            txd_prev_q  <= txd_s;
            // two edges: select is read only after its second flop has a sample
            armed_q     <= 1'b1;
            started_q   <= armed_q;
        end
    end

    wire sel_rise  = sel_s & ~sel_prev_q;    // mode select rising
    wire sel_fall  = ~sel_s & sel_prev_q;    // mode select falling
    wire wake_fall = ~wake_s & wake_prev_q;  // wake falling
    wire txd_rise  = txd_s & ~txd_prev_q;    // transmit rising

    ////////////////////////////////////////////////////////////////////////////
    // timers

    logic bus_active;    // bus held low beyond debounce
    logic txd_timeout;   // transmit held low too long
    logic settled;       // supplies settled in ready

    lintmc_pkg::lintmc_mode_t mode_q;   // current mode
    lintmc_pkg::lintmc_mode_t mode_d;   // next mode

    // debounce bus low before calling it activity
    lintmc_timer u_tmr_bus (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .run     (~bus_s),
        .limit   (lintmc_pkg::CNT_W'(lintmc_pkg::DEBOUNCE_CYCLES)),
        .expired (bus_active)
    );

    // dominant timeout counts only while actually driving
    lintmc_timer u_tmr_txd (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .run     (~txd_s & (mode_q == lintmc_pkg::LINTMC_OPER)),
        .limit   (lintmc_pkg::CNT_W'(lintmc_pkg::TXDOM_CYCLES)),
        .expired (txd_timeout)
    );

    // settle delay before ready hands on to operation
    lintmc_timer u_tmr_set (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .run     (mode_q == lintmc_pkg::LINTMC_READY),
        .limit   (lintmc_pkg::CNT_W'(lintmc_pkg::SETTLE_CYCLES)),
        .expired (settled)
    );

    ////////////////////////////////////////////////////////////////////////////
    // fault tracking

    logic thermal_q;     // thermal shutdown latched
    logic txlatch_q;     // dominant timeout latched until transmit rise
    logic contend;       // bus low while we send recessive

    // overload or overtemperature both trip thermal shutdown
    wire thermal_set = otemp_s | ovld_s;
    // recovery by die temperature alone, set wins over clear
    wire thermal_d   = thermal_set | (thermal_q & ~recov_s);
    // latched timeout clears on the next transmit rising edge
    wire txlatch_d   = txd_timeout | (txlatch_q & ~txd_rise);

    // fault latches
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            thermal_q <= 1'b0;
            txlatch_q <= 1'b0;
        end else begin
            thermal_q <= thermal_d;
            txlatch_q <= txlatch_d;
        end
    end

    // contention: recessive sent yet bus debounced low while in operation mode
    assign contend = (mode_q == lintmc_pkg::LINTMC_OPER) & txd_s & bus_active;

    wire fault_any = thermal_q | contend | txd_timeout | txlatch_q;
    // inhibit pin low, external or our own pull-down
    wire inhibit   = ~inh_s;

    ////////////////////////////////////////////////////////////////////////////
    // mode machine

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            lintmc_pkg::LINTMC_POR: begin
                // sample select once outputs are held off
                if (started_q) begin
                    if (sel_s)
                        mode_d = lintmc_pkg::LINTMC_OPER;
                    else
                        mode_d = lintmc_pkg::LINTMC_READY;
                end
            end
            lintmc_pkg::LINTMC_READY: begin
                // wait for select high; transmit low diverts
                if (sel_s && settled) begin
                    if (!txd_s)
                        mode_d = lintmc_pkg::LINTMC_TXOFF;
                    else
                        mode_d = lintmc_pkg::LINTMC_OPER;
                end
            end
            lintmc_pkg::LINTMC_OPER: begin
                if (sel_fall)
                    mode_d = lintmc_pkg::LINTMC_PDOWN;
                else if (fault_any || inhibit)
                    mode_d = lintmc_pkg::LINTMC_TXOFF;
            end
            lintmc_pkg::LINTMC_TXOFF: begin
                if (sel_fall)
                    mode_d = lintmc_pkg::LINTMC_PDOWN;
                // all clear, bus released, both inputs high
                // a bus still held low is a standing contention; leaving would bounce
                else if (!thermal_q && !txlatch_q && !inhibit && !bus_active &&
                         txd_s && sel_s)
                    mode_d = lintmc_pkg::LINTMC_OPER;
            end
            lintmc_pkg::LINTMC_PDOWN: begin
                if (bus_active || sel_rise || sel_s || wake_fall)
                    mode_d = lintmc_pkg::LINTMC_READY;
            end
            default: mode_d = lintmc_pkg::LINTMC_POR;
        endcase
    end

    // mode register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            mode_q <= lintmc_pkg::LINTMC_POR;
        else
            mode_q <= mode_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // output decode from next mode, registered

    // everything on in operation; ready rx and regulator only
    wire tx_en_d  = (mode_d == lintmc_pkg::LINTMC_OPER);
    // regulator off in power-down and during reset
    wire reg_en_d = (mode_d == lintmc_pkg::LINTMC_READY) |
                    (mode_d == lintmc_pkg::LINTMC_OPER)  |
                    (mode_d == lintmc_pkg::LINTMC_TXOFF);
    wire rx_en_d  = reg_en_d;
    // disabled transmitter forces internal data to one
    wire txd_int  = tx_en_d ? txd_s : 1'b1;
    wire drive_d  = tx_en_d & ~txd_int;
    // receive follows bus whenever receiver or detector listens
    wire rx_low_d = (mode_d != lintmc_pkg::LINTMC_POR) & ~bus_s;
    // inhibit pin pulled low on thermal or dominant-short fault
    wire flag_d   = thermal_q | contend;

    // output flops
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_enable              <= 1'b0;
            reg_enable             <= 1'b0;
            rx_enable              <= 1'b0;
            bus_line_o             <= 1'b0;
            bus_line_oe            <= 1'b0;
            rx_data_o              <= 1'b0;
            rx_data_oe             <= 1'b0;
            tx_inhibit_flag_pin_o  <= 1'b0;
            tx_inhibit_flag_pin_oe <= 1'b0;
            mode_o                 <= 3'h0;
        end else begin
            tx_enable              <= tx_en_d;
            reg_enable             <= reg_en_d;
            rx_enable              <= rx_en_d;
            bus_line_o             <= 1'b0;
            bus_line_oe            <= drive_d;
            rx_data_o              <= 1'b0;
            rx_data_oe             <= rx_low_d;
            tx_inhibit_flag_pin_o  <= 1'b0;
            tx_inhibit_flag_pin_oe <= flag_d;
            mode_o                 <= mode_d;
        end
    end

endmodule
`default_nettype wire

// ==== design/lintmc_pkg.sv ====
/*
 * lintmc_pkg: shared constants and the mode enumeration for the LIN
 * transceiver mode controller.
 * assumes a 100 MHz ref_clk; all times are converted to cycles here.
 */
package lintmc_pkg;

    // clock period in ns
    localparam int unsigned CLK_PERIOD_NS = 10;

    // bus-activity debounce time in ns (least time, rounds up)
    localparam int unsigned DEBOUNCE_TIME_NS = 30000;
    localparam int unsigned DEBOUNCE_CYCLES =
        (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // transmit-dominant timeout in ms (least time, rounds up)
    localparam int unsigned TXDOM_TIME_MS = 10;
    localparam int unsigned TXDOM_CYCLES =
        (TXDOM_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // supply settle time in ns, used for ready to operation hand-off
    localparam int unsigned SETTLE_TIME_NS = 1000;
    localparam int unsigned SETTLE_CYCLES =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // counter width shared by all timers
    localparam int unsigned CNT_W = 24;

    // operating modes
    typedef enum logic [2:0] {
        LINTMC_POR,
        LINTMC_READY,
        LINTMC_OPER,
        LINTMC_TXOFF,
        LINTMC_PDOWN
    } lintmc_mode_t;

endpackage

// ==== design/lintmc_sync.sv ====
/*
 * lintmc_sync: two-flop synchroniser for one level.
 * assumes the input may change at any time relative to ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module lintmc_sync (
    input  wire logic ref_clk,   // system clock
    input  wire logic sys_rst,   // async reset, active high
    input  wire logic rst_val,   // level held during reset
    input  wire logic async_in,  // raw level
    output logic      sync_out   // synchronised level
);
    logic meta_q;   // first stage, read only by second stage

    // two flops; reset loads constants chosen by rst_val via two branches
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // idle level per pin, so no false edge follows reset
            if (rst_val) begin
                meta_q   <= 1'b1;
                sync_out <= 1'b1;
            end else begin
                meta_q   <= 1'b0;
                sync_out <= 1'b0;
            end
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== design/lintmc_timer.sv ====
/*
 * lintmc_timer: counts cycles while a condition holds, flags expiry.
 * assumes limit is static; the count restarts whenever run drops.
 */
`timescale 1ns/1ns
`default_nettype none
module lintmc_timer (
    input  wire logic                          ref_clk,  // system clock
    input  wire logic                          sys_rst,  // async reset
    input  wire logic                          run,      // count while high
    input  wire logic [lintmc_pkg::CNT_W-1:0]  limit,    // cycles to expiry
    output logic                               expired   // level, run held long enough
);
    logic [lintmc_pkg::CNT_W-1:0] cnt_q;   // elapsed cycles
    logic [lintmc_pkg::CNT_W-1:0] cnt_d;   // next count

    // saturate at limit so the flag stays up while run holds
    assign cnt_d = !run ? '0 : (cnt_q == limit) ? cnt_q : cnt_q + 1'b1;

    // counter and flag
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q   <= '0;
            expired <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            expired <= run && (cnt_d == limit);
        end
    end
endmodule
`default_nettype wire

// ==== testbench/lintmc_far.sv ====
/*
 * lintmc_far: wires at the far side of the mode controller, with the other
 * bus node and the host inhibit driver.
 * assumes pull-ups on the bus, inhibit and receive lines; all drivers pull low.
 */
`timescale 1ns/1ns
`default_nettype none
module lintmc_far (
    input  wire logic bus_line_oe,            // controller pulls bus dominant
    input  wire logic tx_inhibit_flag_pin_oe, // controller pulls flag low
    input  wire logic rx_data_oe,             // controller pulls receive low
    input  wire logic other_dom,              // other node drives dominant
    input  wire logic host_inhibit,           // host pulls inhibit pin low
    output logic      bus_line_i,             // resolved bus level
    output logic      tx_inhibit_flag_pin_i,  // resolved inhibit pin level
    output logic      rxd                     // resolved receive line
);
    ////////////////////////////////////////////////////////////////////////////
    // wired-and with pull-up: released lines float high, never hold old value
    // dominant pulls bus
    assign bus_line_i = ~(bus_line_oe | other_dom);
    assign tx_inhibit_flag_pin_i = ~(tx_inhibit_flag_pin_oe | host_inhibit);
    assign rxd = ~rx_data_oe;
endmodule
`default_nettype wire

// ==== testbench/lintmc_top_monitor.sv ====
/*
 * lintmc_top_monitor: concurrent checks on the mode controller ports.
 * assumes mode codes 0 por, 1 ready, 2 oper, 3 txoff, 4 pdown.
 */
`timescale 1ns/1ns
`default_nettype none
module lintmc_top_monitor (
    input  wire logic       ref_clk,               // clock
    input  wire logic       sys_rst,               // async reset
    input  wire logic       mode_select,           // host select
    input  wire logic       tx_data,               // host transmit
    input  wire logic       wake_n,                // wake pin
    input  wire logic       tx_inhibit_flag_pin_i, // inhibit level
    input  wire logic       thermal_overtemp,      // die too hot
    input  wire logic       output_overload,       // driver overcurrent
    input  wire logic       bus_line_oe,           // bus driver enable
    input  wire logic       reg_enable,            // regulator enable
    input  wire logic       rx_enable,             // receiver power
    input  wire logic       tx_enable,             // transmitter enable
    input  wire logic [2:0] mode_o                 // mode code
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    property p_pdown_off;
        mode_o == 3'h4 |-> !tx_enable && !reg_enable && !bus_line_oe;
    endproperty
    a_pdown_off: assert property (p_pdown_off) else $error("pdown outputs on");
    property p_ready_out;
        mode_o == 3'h1 |-> reg_enable && rx_enable && !tx_enable;
    endproperty
    a_ready_out: assert property (p_ready_out) else $error("ready outputs");
    property p_oper_out;
        mode_o == 3'h2 |-> reg_enable && rx_enable && tx_enable;
    endproperty
    a_oper_out: assert property (p_oper_out) else $error("oper outputs");
    property p_por_off;
        mode_o == 3'h0 |-> !reg_enable && !rx_enable && !tx_enable;
    endproperty
    a_por_off: assert property (p_por_off) else $error("por outputs");
    // slack of a few cycles covers the two-flop sync and edge detect
    property p_sel_fall;
        (mode_o == 3'h2 || mode_o == 3'h3) && $fell(mode_select) |-> ##[1:5] mode_o == 3'h4;
    endproperty
    a_sel_fall: assert property (p_sel_fall) else $error("no pdown");
    property p_wake;
        mode_o == 3'h4 && $fell(wake_n) |-> ##[1:5] mode_o == 3'h1;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_fault;
        mode_o == 3'h2 && (thermal_overtemp || output_overload) |-> ##[1:5] mode_o == 3'h3;
    endproperty
    a_fault: assert property (p_fault) else $error("fault kept oper");
    property p_inhibit;
        mode_o == 3'h2 && !tx_inhibit_flag_pin_i |-> ##[1:5] mode_o == 3'h3;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit ignored");
    property p_txd_low;
        mode_o == 3'h1 && $rose(mode_select) && !tx_data |-> ##[1:120] mode_o == 3'h3;
    endproperty
    a_txd_low: assert property (p_txd_low) else $error("no txoff");
    property p_recessive;
        !tx_enable |-> !bus_line_oe;
    endproperty
    a_recessive: assert property (p_recessive) else $error("driving while off");
endmodule
bind lintmc_top lintmc_top_monitor u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .mode_select(mode_select), .tx_data(tx_data), .wake_n(wake_n),
    .tx_inhibit_flag_pin_i(tx_inhibit_flag_pin_i), .thermal_overtemp(thermal_overtemp),
    .output_overload(output_overload), .bus_line_oe(bus_line_oe), .reg_enable(reg_enable),
    .rx_enable(rx_enable), .tx_enable(tx_enable), .mode_o(mode_o));
`default_nettype wire

// ==== testbench/lintmc_top_bench.sv ====
/*
 * lintmc_top_bench: walks the mode controller through its modes and faults, except the dominant timeout.
 * assumes lintmc_far resolves the wires; inputs change on the falling edge.
 */
`timescale 1ns/1ns
`default_nettype none
module lintmc_top_bench;
    logic ref_clk = 1'b0, sys_rst = 1'b1, mode_select = 1'b0, tx_data = 1'b1;
    logic wake_n = 1'b1, thermal_overtemp = 1'b0, output_overload = 1'b0;
    logic thermal_recovered = 1'b1, other_dom = 1'b0, host_inhibit = 1'b0;
    logic bus_line_i, flag_i, bus_oe, rx_oe, flag_oe, reg_enable, rx_enable, tx_enable, rxd;
    logic [2:0] mode_o;
    int n_fail = 0, num_checks = 0, cyc = 0;
    lintmc_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .mode_select(mode_select),
        .tx_data(tx_data), .wake_n(wake_n), .tx_inhibit_flag_pin_i(flag_i),
        .bus_line_i(bus_line_i), .thermal_overtemp(thermal_overtemp),
        .output_overload(output_overload), .thermal_recovered(thermal_recovered),
        .bus_line_o(), .bus_line_oe(bus_oe), .rx_data_o(), .rx_data_oe(rx_oe),
        .tx_inhibit_flag_pin_o(), .tx_inhibit_flag_pin_oe(flag_oe),
        .reg_enable(reg_enable), .rx_enable(rx_enable), .tx_enable(tx_enable),
        .mode_o(mode_o));
    lintmc_far far (.bus_line_oe(bus_oe), .tx_inhibit_flag_pin_oe(flag_oe),
        .rx_data_oe(rx_oe), .other_dom(other_dom), .host_inhibit(host_inhibit),
        .bus_line_i(bus_line_i), .tx_inhibit_flag_pin_i(flag_i), .rxd(rxd));
    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; ceiling is about two and a half times the expected run
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // bounded wait for a mode, then compare
    task automatic wait_mode(input logic [2:0] e, input int lim);
        int k;
        k = 0;
        while (mode_o !== e && k < lim) begin
            step(1);
            k++;
        end
        chk("mode_o", e, mode_o);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        step(16);
        sys_rst = 1'b0;
        wait_mode(3'h1, 10);
        chk("outs", 3'h6, {reg_enable, rx_enable, tx_enable});
        step(200);
        tx_data = 1'b0;
        mode_select = 1'b1;
        wait_mode(3'h3, 200);
        tx_data = 1'b1;
        wait_mode(3'h2, 200);
        tx_data = 1'b0;
        step(6);
        chk("drive", 3'h3, {1'b0, bus_oe, rx_oe});
        tx_data = 1'b1;
        step(6);
        chk("drive", 3'h0, {1'b0, bus_oe, rx_oe});
        // three fault kinds: overtemp, overload, host inhibit
        for (int i = 0; i < 3; i++) begin
            thermal_recovered = 1'b0;
            thermal_overtemp = (i == 0);
            output_overload = (i == 1);
            host_inhibit = (i == 2);
            tx_data = (i == 2);
            wait_mode(3'h3, 10);
            chk("txen", 3'h0, {2'h0, tx_enable});
            step(20);
            chk("rxtx", (i == 2) ? 3'h3 : 3'h2, {1'b0, rxd, tx_data});
            thermal_overtemp = 1'b0;
            output_overload = 1'b0;
            host_inhibit = 1'b0;
            thermal_recovered = 1'b1;
            tx_data = 1'b1;
            wait_mode(3'h2, 200);
        end
        // contention: bus held low while transmit idles high
        other_dom = 1'b1;
        wait_mode(3'h3, 3200);
        chk("flag", 3'h1, {2'h0, flag_oe});
        chk("rxtx", 3'h1, {1'b0, rxd, tx_data});
        other_dom = 1'b0;
        wait_mode(3'h2, 200);
        mode_select = 1'b0;
        wait_mode(3'h4, 10);
        chk("outs", 3'h0, {reg_enable, tx_enable, bus_oe});
        other_dom = 1'b1;
        step(1000);
        other_dom = 1'b0;
        step(10);
        chk("mode_o", 3'h4, mode_o);
        other_dom = 1'b1;
        wait_mode(3'h1, 3200);
        other_dom = 1'b0;
        step(200);
        mode_select = 1'b1;
        wait_mode(3'h2, 200);
        host_inhibit = 1'b1;
        wait_mode(3'h3, 10);
        mode_select = 1'b0;
        wait_mode(3'h4, 10);
        host_inhibit = 1'b0;
        step(10);
        wake_n = 1'b0;
        wait_mode(3'h1, 10);
        wake_n = 1'b1;
        step(200);
        mode_select = 1'b1;
        step(10);
        mode_select = 1'b0;
        wait_mode(3'h4, 10);
        step(10);
        mode_select = 1'b1;
        wait_mode(3'h1, 10);
        wait_mode(3'h2, 200);
        // second reset with select high goes straight to operation
        sys_rst = 1'b1;
        step(16);
        sys_rst = 1'b0;
        wait_mode(3'h2, 10);
        complete_run();
    end
endmodule
`default_nettype wire
